/* src/opcode_map_decoder.sv */
// Opcode map decoder: fetches opcode and operand bytes and forms operand addresses.
// Assumes program memory answers a read in the same cycle (combinational data).
// Summary of operation
// RL1 - Opcode 9f copies the index register into the accumulator, keeps all flags, takes 2 cycles.
// RL2 - Opcode 8f clears the interrupt mask and halts the core clock until an interrupt, 2 cycles.
// RL3 - The high nibble picks group and addressing column, the low nibble picks the operation.
// RL4 - Absolute addressing fetches high then low address byte as a 16-bit operand address.
// RL5 - Word-offset indexing fetches high then low offset and adds it to the index register.
// RL6 - Byte-offset indexing fetches one offset byte and adds it to the index register.
// RL7 - Plain indexing uses the index register as address and is a single opcode byte.
// RL8 - Column 0 bit branches are 3 bytes, low bit picks set or clear, bits 3:1 the bit, 5 cycles.
// RL9 - Column 2 relative branches are 2 bytes with a signed offset byte, 3 cycles.
// RL10 - Operand field is zero, one or two bytes after the opcode, counted by the column's mode.
// RL11 - Opcode and operands come from incrementing addresses; the counter passes them first.
// RL12 - Opcode 8e clears the interrupt mask and stops the oscillator until an interrupt.
`timescale 1ns/100ps
module opcode_map_decoder (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] mem_data_i,
  input wire logic [7:0] index_i,
  input wire logic [7:0] acc_i,
  input wire logic irq_i,
  output logic [15:0] mem_addr_o,
  output logic mem_rd_o,
  output opdec_pkg::decode_t dec_o,
  output logic dec_valid_o,
  output logic acc_load_o,
  output logic [7:0] acc_data_o,
  output logic irq_mask_clr_o,
  output logic cpu_halt_o,
  output logic osc_stop_o
);
  typedef struct packed {
    opdec_pkg::dec_state_t state;
    logic [15:0] pc;
    logic [1:0] opnd_left;
    logic [15:0] opnd;
    logic [3:0] cyc_cnt;
    logic irq_s1;
    logic irq_s2;
    opdec_pkg::decode_t dec;
    logic dec_valid;
    logic acc_load;
    logic [7:0] acc_data;
    logic mask_clr;
    logic halt;
    logic osc_stop;
  } core_t;

  core_t cur_ff;
  core_t nxt_ff;

  // Column to addressing mode
  function automatic opdec_pkg::addr_mode_t col_mode(input logic [3:0] col);
    case (col)
      4'h0: col_mode = opdec_pkg::AM_BIT_BRANCH;
      4'h1: col_mode = opdec_pkg::AM_BIT_DIRECT;
      4'h2: col_mode = opdec_pkg::AM_RELATIVE;
      4'h3: col_mode = opdec_pkg::AM_DIRECT;
      4'h6: col_mode = opdec_pkg::AM_INDEX_BYTE;
      4'h7: col_mode = opdec_pkg::AM_INDEX_PLAIN;
      4'ha: col_mode = opdec_pkg::AM_IMMEDIATE;
      4'hb: col_mode = opdec_pkg::AM_DIRECT;
      4'hc: col_mode = opdec_pkg::AM_ABSOLUTE;
      4'hd: col_mode = opdec_pkg::AM_INDEX_WORD;
      4'he: col_mode = opdec_pkg::AM_INDEX_BYTE;
      4'hf: col_mode = opdec_pkg::AM_INDEX_PLAIN;
      default: col_mode = opdec_pkg::AM_IMPLIED;
    endcase
  endfunction

  // Operand byte count per mode
  function automatic logic [1:0] opnd_count(input opdec_pkg::addr_mode_t m);
    case (m)
      opdec_pkg::AM_BIT_BRANCH, opdec_pkg::AM_ABSOLUTE, opdec_pkg::AM_INDEX_WORD: opnd_count = 2'h2;
      opdec_pkg::AM_IMPLIED, opdec_pkg::AM_INDEX_PLAIN: opnd_count = 2'h0;
      default: opnd_count = 2'h1;
    endcase
  endfunction

  always_comb begin
    opdec_pkg::addr_mode_t m;
    logic [1:0] cnt;
    m = col_mode(mem_data_i[7:4]);
    cnt = opnd_count(m);
    nxt_ff = cur_ff;
    nxt_ff.irq_s1 = irq_i;
    nxt_ff.irq_s2 = cur_ff.irq_s1;
    nxt_ff.dec_valid = 1'b0;
    nxt_ff.acc_load = 1'b0;
    nxt_ff.mask_clr = 1'b0;
    case (cur_ff.state)
      opdec_pkg::ST_FETCH_OP: begin
        nxt_ff.pc = cur_ff.pc + 16'h0001; // see RL11
        nxt_ff.dec.opcode = mem_data_i;
        nxt_ff.dec.group = mem_data_i[7:4]; // see RL3
        nxt_ff.dec.operation = mem_data_i[3:0]; // see RL3
        nxt_ff.dec.mode = m;
        nxt_ff.dec.length = cnt + opdec_pkg::LEN_ONE; // see RL10
        nxt_ff.dec.bit_num = mem_data_i[3:1]; // see RL8
        nxt_ff.dec.bit_test_set = ~mem_data_i[0]; // see RL8
        nxt_ff.dec.branch_off = 8'h00;
        nxt_ff.opnd = 16'h0000;
        nxt_ff.opnd_left = cnt;
        if (m == opdec_pkg::AM_BIT_BRANCH) begin
          nxt_ff.dec.cycles = opdec_pkg::CYC_BIT_BRANCH; // see RL8
        end else if (m == opdec_pkg::AM_RELATIVE) begin
          nxt_ff.dec.cycles = opdec_pkg::CYC_REL_BRANCH; // see RL9
        end else if (mem_data_i == opdec_pkg::OP_COPY_INDEX_TO_ACC ||
                     mem_data_i == opdec_pkg::OP_WAIT ||
                     mem_data_i == opdec_pkg::OP_STOP) begin
          nxt_ff.dec.cycles = opdec_pkg::CYC_INHERENT_CTRL; // see RL1
        end else begin
          nxt_ff.dec.cycles = opdec_pkg::CYC_DEFAULT;
        end
        nxt_ff.state = (cnt == 2'h0) ? opdec_pkg::ST_EXEC : opdec_pkg::ST_FETCH_OPND; // see RL7
      end
      opdec_pkg::ST_FETCH_OPND: begin
        // High byte arrives first, shifted up as the low byte follows
        nxt_ff.pc = cur_ff.pc + 16'h0001; // see RL11
        nxt_ff.opnd = {cur_ff.opnd[7:0], mem_data_i}; // see RL4
        nxt_ff.opnd_left = cur_ff.opnd_left - 2'h1;
        if (cur_ff.opnd_left == 2'h1) begin
          nxt_ff.state = opdec_pkg::ST_EXEC;
        end
      end
      opdec_pkg::ST_EXEC: begin
        case (cur_ff.dec.mode)
          opdec_pkg::AM_ABSOLUTE: nxt_ff.dec.eff_addr = cur_ff.opnd; // see RL4
          opdec_pkg::AM_INDEX_WORD: nxt_ff.dec.eff_addr = cur_ff.opnd + {8'h00, index_i}; // see RL5
          opdec_pkg::AM_INDEX_BYTE:
            nxt_ff.dec.eff_addr = {8'h00, cur_ff.opnd[7:0]} + {8'h00, index_i}; // see RL6
          opdec_pkg::AM_INDEX_PLAIN: nxt_ff.dec.eff_addr = {8'h00, index_i}; // see RL7
          opdec_pkg::AM_DIRECT, opdec_pkg::AM_BIT_DIRECT:
            nxt_ff.dec.eff_addr = {8'h00, cur_ff.opnd[7:0]};
          opdec_pkg::AM_BIT_BRANCH: begin
            nxt_ff.dec.eff_addr = {8'h00, cur_ff.opnd[15:8]}; // see RL8
            nxt_ff.dec.branch_off = cur_ff.opnd[7:0]; // see RL8
          end
          opdec_pkg::AM_RELATIVE: begin
            // Target if taken; pc already past the offset byte
            nxt_ff.dec.branch_off = cur_ff.opnd[7:0];
            nxt_ff.dec.eff_addr = cur_ff.pc + {{8{cur_ff.opnd[7]}}, cur_ff.opnd[7:0]}; // see RL9
          end
          default: nxt_ff.dec.eff_addr = {8'h00, cur_ff.opnd[7:0]};
        endcase
        nxt_ff.dec_valid = 1'b1;
        if (cur_ff.dec.opcode == opdec_pkg::OP_COPY_INDEX_TO_ACC) begin
          nxt_ff.acc_load = 1'b1; // see RL1
          nxt_ff.acc_data = index_i; // see RL1
        end
        if (cur_ff.dec.opcode == opdec_pkg::OP_WAIT || cur_ff.dec.opcode == opdec_pkg::OP_STOP) begin
          nxt_ff.mask_clr = 1'b1; // see RL2
          nxt_ff.halt = 1'b1; // see RL2
          nxt_ff.osc_stop = (cur_ff.dec.opcode == opdec_pkg::OP_STOP); // see RL12
          nxt_ff.state = opdec_pkg::ST_HALT;
        end else begin
          nxt_ff.state = opdec_pkg::ST_FETCH_OP;
        end
      end
      opdec_pkg::ST_HALT: begin
        // Wake only on the synchronised interrupt level
        if (cur_ff.irq_s2) begin
          nxt_ff.halt = 1'b0; // see RL2
          nxt_ff.osc_stop = 1'b0; // see RL12
          nxt_ff.state = opdec_pkg::ST_FETCH_OP;
        end
      end
      default: nxt_ff.state = opdec_pkg::ST_FETCH_OP;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Address and read strobe registered: pc already points at the next byte
  logic [15:0] addr_ff;
  logic rd_ff;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_ff <= opdec_pkg::PC_RESET;
      // Reset state is opcode fetch, so the first byte must be read at the first edge
      rd_ff <= 1'b1; // see RL11
    end else begin
      addr_ff <= nxt_ff.pc;
      rd_ff <= (nxt_ff.state == opdec_pkg::ST_FETCH_OP) ||
               (nxt_ff.state == opdec_pkg::ST_FETCH_OPND);
    end
  end

  assign mem_addr_o = addr_ff;
  assign mem_rd_o = rd_ff;
  assign dec_o = cur_ff.dec;
  assign dec_valid_o = cur_ff.dec_valid;
  assign acc_load_o = cur_ff.acc_load;
  assign acc_data_o = cur_ff.acc_data;
  assign irq_mask_clr_o = cur_ff.mask_clr;
  assign cpu_halt_o = cur_ff.halt;
  assign osc_stop_o = cur_ff.osc_stop;
endmodule

/* src/opdec_pkg.sv */
// Package for the opcode map decoder: addressing modes, opcode constants, decode record.
// Assumes an 8-bit core with a 16-bit program counter and byte-wide program memory.
package opdec_pkg;
  typedef enum logic [3:0] {
    AM_IMPLIED, AM_IMMEDIATE, AM_DIRECT, AM_ABSOLUTE, AM_INDEX_WORD,
    AM_INDEX_BYTE, AM_INDEX_PLAIN, AM_RELATIVE, AM_BIT_BRANCH, AM_BIT_DIRECT
  } addr_mode_t;

  typedef enum logic [1:0] {
    ST_FETCH_OP, ST_FETCH_OPND, ST_EXEC, ST_HALT
  } dec_state_t;

  localparam logic [7:0] OP_COPY_INDEX_TO_ACC = 8'h9f;
  localparam logic [7:0] OP_WAIT = 8'h8f;
  localparam logic [7:0] OP_STOP = 8'h8e;
  localparam logic [3:0] COL_BIT_BRANCH = 4'h0;
  localparam logic [3:0] COL_REL_BRANCH = 4'h2;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [3:0] CYC_INHERENT_CTRL = 4'h2;
  localparam logic [3:0] CYC_BIT_BRANCH = 4'h5;
  localparam logic [3:0] CYC_REL_BRANCH = 4'h3;
  localparam logic [3:0] CYC_DEFAULT = 4'h3;
  localparam logic [1:0] LEN_ONE = 2'h1;

  typedef struct packed {
    logic [7:0] opcode;
    logic [3:0] group;
    logic [3:0] operation;
    addr_mode_t mode;
    logic [1:0] length;
    logic [3:0] cycles;
    logic [15:0] eff_addr;
    logic [7:0] branch_off;
    logic [2:0] bit_num;
    logic bit_test_set;
  } decode_t;
endpackage

/* testbench/prog_mem_model.sv */
// Program memory model: answers a read in the same cycle at the fetch address.
// Assumes the bench loads mem before reset is released; 256 bytes mirrored.
`timescale 1ns/100ps
module prog_mem_model (
  input wire logic sys_clk_i,
  input wire logic mem_rd_i,
  input wire logic [15:0] mem_addr_i,
  output logic [7:0] mem_data_o
);
  logic [7:0] mem [256];
  logic [7:0] last_ff = 8'h5a;
  // Idle bus shows the inverted last byte so a stale value never passes
  assign mem_data_o = mem_rd_i ? mem[mem_addr_i[7:0]] : ~last_ff;
  always @(posedge sys_clk_i) if (mem_rd_i) last_ff <= mem[mem_addr_i[7:0]];
endmodule

/* testbench/opcode_map_decoder_props.sv */
// Checker on the decoder ports.
// Assumes index_i stays steady while an instruction decodes.
`timescale 1ns/100ps
module opcode_map_decoder_props (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic irq_i,
  input wire logic [7:0] index_i,
  input wire logic mem_rd_o,
  input wire opdec_pkg::decode_t dec_o,
  input wire logic dec_valid_o,
  input wire logic acc_load_o,
  input wire logic [7:0] acc_data_o,
  input wire logic irq_mask_clr_o,
  input wire logic cpu_halt_o,
  input wire logic osc_stop_o
);
  logic [7:0] op;
  assign op = dec_o.opcode;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence halt_entry;
    irq_mask_clr_o ##[0:2] cpu_halt_o;
  endsequence
  // Opcode edge, two operand edges, then a quiet exec edge
  sequence three_fetch;
    $past(mem_rd_o, 4) && $past(mem_rd_o, 3) && $past(mem_rd_o, 2) && !$past(mem_rd_o);
  endsequence
  AST_NIBBLE: assert property (dec_valid_o |-> dec_o.group == op[7:4] && dec_o.operation == op[3:0]) else $error("nibble split wrong");
  AST_COPY: assert property (dec_valid_o && op == 8'h9f |-> acc_load_o && acc_data_o == index_i && dec_o.cycles == 4'h2 && dec_o.mode == opdec_pkg::AM_IMPLIED) else $error("index copy wrong");
  AST_LOAD_ONLY: assert property (acc_load_o |-> dec_valid_o && op == 8'h9f) else $error("stray acc load");
  AST_WAIT: assert property (dec_valid_o && op == 8'h8f |-> dec_o.cycles == 4'h2 ##0 halt_entry ##0 !osc_stop_o) else $error("wait entry wrong");
  AST_STOP: assert property (dec_valid_o && op == 8'h8e |-> dec_o.cycles == 4'h2 ##0 halt_entry ##0 osc_stop_o) else $error("stop entry wrong");
  AST_ASLEEP: assert property (cpu_halt_o |-> !mem_rd_o) else $error("fetch while halted");
  AST_WAKE: assert property (cpu_halt_o && $rose(irq_i) |-> ##[1:4] !cpu_halt_o) else $error("no wake");
  AST_BIT_BRANCH: assert property (dec_valid_o && op[7:4] == 4'h0 |-> dec_o.length == 2'h3 && dec_o.cycles == 4'h5 && dec_o.bit_num == op[3:1] && dec_o.bit_test_set == !op[0]) else $error("bit branch wrong");
  AST_REL_BRANCH: assert property (dec_valid_o && op[7:4] == 4'h2 |-> dec_o.length == 2'h2 && dec_o.cycles == 4'h3 && dec_o.mode == opdec_pkg::AM_RELATIVE) else $error("branch wrong");
  AST_PLAIN: assert property (dec_valid_o && dec_o.mode == opdec_pkg::AM_INDEX_PLAIN |-> dec_o.length == 2'h1 && dec_o.eff_addr == {8'h00, index_i}) else $error("plain index wrong");
  AST_THREE_FETCH: assert property (dec_valid_o && dec_o.length == 2'h3 |-> three_fetch) else $error("fetch count wrong");
endmodule
bind opcode_map_decoder opcode_map_decoder_props i_props (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
  .irq_i(irq_i), .index_i(index_i), .mem_rd_o(mem_rd_o), .dec_o(dec_o), .dec_valid_o(dec_valid_o),
  .acc_load_o(acc_load_o), .acc_data_o(acc_data_o), .irq_mask_clr_o(irq_mask_clr_o),
  .cpu_halt_o(cpu_halt_o), .osc_stop_o(osc_stop_o));

/* testbench/tb.sv */
// Self-checking bench: random program in the memory model, decodes checked in order.
// Assumes the decoder fetches sequentially and never redirects the fetch address.
`timescale 1ns/100ps
module tb;
  logic sys_clk_i, rstn_i, irq_i, mem_rd_o, dec_valid_o, acc_load_o, irq_mask_clr_o;
  logic cpu_halt_o, osc_stop_o;
  logic [7:0] mem_data_i, index_i, acc_i, acc_data_o, op;
  logic [15:0] mem_addr_o, pc;
  opdec_pkg::decode_t dec_o;
  int miscompares = 0, compares = 0, seed = 32'h034335f4, n;
  logic [7:0] q_op[$], q_b1[$], q_b2[$];
  logic [15:0] q_pc[$];
  logic [7:0] corner[9] = '{8'h9f, 8'hc6, 8'hd6, 8'he6, 8'hf6, 8'h01, 8'h2f, 8'h20, 8'h3f};
  opcode_map_decoder i_opcode_map_decoder (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .mem_data_i(mem_data_i), .index_i(index_i), .acc_i(acc_i), .irq_i(irq_i),
    .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .dec_o(dec_o), .dec_valid_o(dec_valid_o),
    .acc_load_o(acc_load_o), .acc_data_o(acc_data_o), .irq_mask_clr_o(irq_mask_clr_o),
    .cpu_halt_o(cpu_halt_o), .osc_stop_o(osc_stop_o));
  prog_mem_model i_prog_mem_model (.sys_clk_i(sys_clk_i), .mem_rd_i(mem_rd_o),
    .mem_addr_i(mem_addr_o), .mem_data_o(mem_data_i));
  // Byte count per column, column 0 in the low nibble
  function automatic logic [1:0] exp_len(logic [7:0] o);
    logic [63:0] t = 64'h1233_2211_1211_2223;
    return t[o[7:4] * 4 +: 2];
  endfunction
  function automatic logic [15:0] exp_ea(logic [7:0] o, b1, b2, logic [15:0] a);
    case (o[7:4])
      4'h2: return a + 16'h2 + {{8{b1[7]}}, b1};
      4'hc: return {b1, b2};
      4'hd: return {b1, b2} + index_i;
      4'h6, 4'he: return b1 + index_i;
      default: return {8'h00, index_i};
    endcase
  endfunction
  task automatic end_sim();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic put(logic [7:0] o);
    logic [7:0] b1 = $random(seed);
    logic [7:0] b2 = $random(seed);
    i_prog_mem_model.mem[pc[7:0]] = o;
    i_prog_mem_model.mem[pc[7:0] + 8'h1] = b1;
    i_prog_mem_model.mem[pc[7:0] + 8'h2] = b2;
    q_op.push_back(o);
    q_b1.push_back(b1);
    q_b2.push_back(b2);
    q_pc.push_back(pc);
    pc = pc + exp_len(o);
  endtask
  // Bounded wait: 0 halted, 1 oscillator stopped, 2 awake, 3 all decodes seen
  task automatic wt(int k);
    for (n = 0; n < 3000; n++) begin
      @(negedge sys_clk_i);
      if (k == 0 && cpu_halt_o === 1'b1 || k == 1 && osc_stop_o === 1'b1) return;
      if (k == 2 && cpu_halt_o === 1'b0 || k == 3 && q_op.size() == 0) return;
    end
    miscompares++;
    end_sim();
  endtask
  always @(negedge sys_clk_i) begin
    if (dec_valid_o === 1'b1 && q_op.size() > 0) begin
      chk(dec_o.opcode, q_op[0]);
      chk(dec_o.length, exp_len(q_op[0]));
      if (q_op[0][7:4] inside {4'h2, 4'h6, 4'h7, [4'hc:4'hf]})
        chk(dec_o.eff_addr, exp_ea(q_op[0], q_b1[0], q_b2[0], q_pc[0]));
      if (q_op[0][7:4] == 4'h0) chk(dec_o.branch_off, q_b2[0]);
      if (!(q_op[0] inside {8'h8e, 8'h8f})) chk(mem_addr_o, q_pc[0] + exp_len(q_op[0]));
      void'(q_op.pop_front());
      void'(q_b1.pop_front());
      void'(q_b2.pop_front());
      void'(q_pc.pop_front());
    end
  end
  initial begin
    sys_clk_i = 0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    rstn_i = 0;
    irq_i = 0;
    pc = 0;
    // High index values push the offset sums across a byte carry
    index_i = 8'hf0 | $random(seed);
    acc_i = $random(seed);
    for (n = 0; n < 256; n++) i_prog_mem_model.mem[n] = 8'h9d;
    for (n = 0; n < 8; n++) put(8'h00);
    for (n = 0; n < 9; n++) put(corner[n]);
    for (n = 0; n < 30; n++) begin
      do op = $random(seed); while (op == 8'h8e || op == 8'h8f);
      put(op);
    end
    put(8'h8f);
    put(8'h9f);
    put(8'h8e);
    put(8'hd7);
    repeat (3) @(negedge sys_clk_i);
    rstn_i = 1;
    wt(0);
    chk(osc_stop_o, 16'h0);
    repeat (4) @(negedge sys_clk_i);
    chk(mem_rd_o, 16'h0);
    irq_i = 1;
    wt(2);
    irq_i = 0;
    wt(1);
    chk(cpu_halt_o, 16'h1);
    irq_i = 1;
    wt(2);
    irq_i = 0;
    chk(osc_stop_o, 16'h0);
    wt(3);
    end_sim();
  end
endmodule
